// file: inc/trace_tap_pkg.sv
`default_nettype none
package trace_tap_pkg;
  // Observation group shape
  localparam int GROUP_COUNT = 12;
  localparam int GROUP_W     = 128;
  localparam int QUAL_W      = 4;
  localparam int SNAP_DEPTH  = 16;

  // Walk port width thresholds and the group sets they enable
  localparam int WALK_W_NARROW = 128;
  localparam int WALK_W_MID    = 256;
  localparam int WALK_W_WIDE   = 512;
  localparam logic [GROUP_COUNT-1:0] MASK_NARROW = 12'h47F;
  localparam logic [GROUP_COUNT-1:0] MASK_MID    = 12'hCFF;
  localparam logic [GROUP_COUNT-1:0] MASK_WIDE   = 12'hFFF;
  localparam logic [GROUP_COUNT-1:0] MASK_NONE   = 12'h000;

  // Implemented groups and their delays in cycles
  localparam int GRP_DN    = 0;
  localparam int GRP_UP    = 1;
  localparam int GRP_EXT   = 2;
  localparam int GRP_WALK  = 3;
  localparam int GRP_FIRST_IDLE = 4;
  localparam int DLY_DN    = 1;
  localparam int DLY_UP    = 1;
  localparam int DLY_EXT   = 0;
  localparam int DLY_WALK  = 1;

  // Translation message stream fields
  localparam int MSG_W     = 160;
  localparam int MSG_EXT_W = 32;
  localparam int ID_W      = 6;
  localparam int KEEP_W    = 20;
  localparam int G2_PAD_W  = 4;

  // Walk read channel fields
  localparam int G3_PAD_W  = 1;
  localparam int POISON_W  = 8;
  localparam int RID_W     = 11;
  localparam int MPAM_W    = 11;
  localparam int DOMAIN_W  = 2;
  localparam int USER_W    = 4;
  localparam int QOS_W     = 4;
  localparam int CACHE_W   = 4;
  localparam int BURST_W   = 2;
  localparam int SIZE_W    = 3;
  localparam int LEN_W     = 8;
  localparam int ADDR_W    = 52;

  localparam logic [GROUP_W-1:0] GROUP_ZERO = 128'h0;
  localparam logic [QUAL_W-1:0]  QUAL_ZERO  = 4'h0;
endpackage : trace_tap_pkg
`default_nettype wire

// file: inc/snap_stream_if.sv
`default_nettype none
interface snap_stream_if #(
  parameter int WIDTH = 128
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : snap_stream_if
`default_nettype wire

// file: rtl/snap_word_fifo.sv
`default_nettype none
module snap_word_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  // Streams
  snap_stream_if.snk fill_in,
  snap_stream_if.src drain_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r,  wr_nxt;
  logic [AW-1:0]    rd_r,  rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             ov_r,  ov_nxt;
  logic [WIDTH-1:0] od_r,  od_nxt;
  logic             push;
  logic             load;

  // Output register adds one slot beyond the memory
  always_comb begin
    fill_in.ready = (cnt_r != (AW+1)'(DEPTH));
    push    = fill_in.valid & fill_in.ready;
    load    = (cnt_r != '0) && (!ov_r || drain_out.ready);
    wr_nxt  = push ? wr_r + 1'b1 : wr_r;
    rd_nxt  = load ? rd_r + 1'b1 : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(load);
    od_nxt  = load ? mem[rd_r] : od_r;
    ov_nxt  = load | (ov_r & ~drain_out.ready);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      ov_r  <= 1'b0;
      od_r  <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
      ov_r  <= ov_nxt;
      od_r  <= od_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_r] <= fill_in.data;
    end
  end

  assign drain_out.valid = ov_r;
  assign drain_out.data  = od_r;
endmodule : snap_word_fifo
`default_nettype wire

// file: rtl/translation_unit_trace_tap.sv
`default_nettype none
// Contract
// - enabled groups drive sample enable high
// - tap enable low clears all enables
// - width up to 128: groups 0-6,10
// - width 256: groups 0-7,10,11
// - width 512: all twelve groups
// - 128-bit groups, wide buses staggered chunks
// - each field at its fixed delay
// - group 0: downstream data, delay 1
// - group 1: upstream data, delay 1
// - group 2: zero delay, stream qualifier
// - group 2: id, upper data, keeps, flags
// - group 3: delay 1, walk qualifier
// - group 3 upper: read response fields
// - group 3 lower: read address fields
module translation_unit_trace_tap
  import trace_tap_pkg::*;
#(
  parameter int WALK_DATA_WIDTH = WALK_W_NARROW,
  parameter int FIFO_DEPTH      = SNAP_DEPTH
) (
  // Clock and reset
  input  wire logic                           clk_in,
  input  wire logic                           rst_n_in,
  // Analyzer control
  input  wire logic                           tap_enable_in,
  // Downstream translation message stream
  input  wire logic [MSG_W-1:0]               downstream_msg_data_in,
  input  wire logic [ID_W-1:0]                downstream_master_id_in,
  input  wire logic [KEEP_W-1:0]              downstream_byte_keeps_in,
  input  wire logic                           downstream_last_in,
  input  wire logic                           downstream_wakeup_in,
  input  wire logic                           downstream_ready_in,
  input  wire logic                           downstream_valid_in,
  // Upstream translation message stream
  input  wire logic [MSG_W-1:0]               upstream_msg_data_in,
  input  wire logic [ID_W-1:0]                upstream_dest_id_in,
  input  wire logic [KEEP_W-1:0]              upstream_byte_keeps_in,
  input  wire logic                           upstream_last_in,
  input  wire logic                           upstream_wakeup_in,
  input  wire logic                           upstream_ready_in,
  input  wire logic                           upstream_valid_in,
  // Table walk read response
  input  wire logic                           walk_rsp_id_unique_in,
  input  wire logic [POISON_W-1:0]            walk_rsp_poison_in,
  input  wire logic                           walk_rsp_last_in,
  input  wire logic [RID_W-1:0]               walk_rsp_id_in,
  input  wire logic                           walk_rsp_ready_in,
  input  wire logic                           walk_rsp_valid_in,
  // Table walk read address
  input  wire logic [RID_W-1:0]               walk_req_id_in,
  input  wire logic                           walk_req_id_unique_in,
  input  wire logic [MPAM_W-1:0]              walk_req_mpam_in,
  input  wire logic [DOMAIN_W-1:0]            walk_req_domain_in,
  input  wire logic [USER_W-1:0]              walk_req_user_in,
  input  wire logic [QOS_W-1:0]               walk_req_qos_in,
  input  wire logic [CACHE_W-1:0]             walk_req_cache_in,
  input  wire logic [BURST_W-1:0]             walk_req_burst_in,
  input  wire logic [SIZE_W-1:0]              walk_req_size_in,
  input  wire logic [LEN_W-1:0]               walk_req_len_in,
  input  wire logic [ADDR_W-1:0]              walk_req_addr_in,
  input  wire logic                           walk_req_ready_in,
  input  wire logic                           walk_req_valid_in,
  // Observation groups to the analyzer
  output logic [GROUP_COUNT-1:0][GROUP_W-1:0] observation_group_bus_out,
  output logic [GROUP_COUNT-1:0][QUAL_W-1:0]  group_qualifier_out,
  output logic [GROUP_COUNT-1:0]              group_sample_enable_out,
  // Downstream beat snapshot drain
  output logic                                snap_room_out,
  output logic                                snap_valid_out,
  output logic [GROUP_W-1:0]                  snap_data_out,
  input  wire logic                           snap_ready_in
);

  // Group set for a walk port width; odd widths fall to the narrow set
  function automatic logic [GROUP_COUNT-1:0] group_mask(input int width);
    logic [GROUP_COUNT-1:0] m;
    m = MASK_NONE;
    if (width <= WALK_W_NARROW) begin
      m = MASK_NARROW;
    end else if (width == WALK_W_MID) begin
      m = MASK_MID;
    end else if (width == WALK_W_WIDE) begin
      m = MASK_WIDE;
    end else begin
      m = MASK_NARROW;
    end
    return m;
  endfunction : group_mask

  // Beat transfer on a ready/valid pair
  function automatic logic beat(input logic ready, input logic valid);
    return ready & valid;
  endfunction : beat

  // Qualifier shared by the two stream data groups
  function automatic logic [QUAL_W-1:0] stream_qual(input logic ready, input logic valid);
    return {1'b0, beat(ready, valid), ready, valid};
  endfunction : stream_qual

  // Side block of group 2; both streams share one layout
  function automatic logic [ID_W+MSG_EXT_W+KEEP_W+3:0] stream_side(
    input logic [ID_W-1:0]      id,
    input logic [MSG_EXT_W-1:0] hi,
    input logic [KEEP_W-1:0]    keeps,
    input logic                 last,
    input logic                 wakeup,
    input logic                 ready,
    input logic                 valid
  );
    return {id, hi, keeps, last, wakeup, ready, valid};
  endfunction : stream_side

  // Fixed at elaboration; the walk width never changes at run time
  localparam logic [GROUP_COUNT-1:0] CFG_MASK = group_mask(WALK_DATA_WIDTH);

  logic                 dn_hs;
  logic                 up_hs;
  logic                 rsp_hs;
  logic                 req_hs;
  logic [GROUP_W-1:0]   g0_r, g0_nxt;
  logic [QUAL_W-1:0]    q0_r, q0_nxt;
  logic [GROUP_W-1:0]   g1_r, g1_nxt;
  logic [QUAL_W-1:0]    q1_r, q1_nxt;
  logic [GROUP_W-1:0]   g2;
  logic [QUAL_W-1:0]    q2;
  logic [GROUP_W-1:0]   g3_r, g3_nxt;
  logic [QUAL_W-1:0]    q3_r, q3_nxt;

  snap_stream_if #(.WIDTH(GROUP_W)) snap_fill ();
  snap_stream_if #(.WIDTH(GROUP_W)) snap_drain ();

  // Handshakes shared by the qualifiers and the snapshot
  assign dn_hs  = beat(downstream_ready_in, downstream_valid_in);
  assign up_hs  = beat(upstream_ready_in, upstream_valid_in);
  assign rsp_hs = beat(walk_rsp_ready_in, walk_rsp_valid_in);
  assign req_hs = beat(walk_req_ready_in, walk_req_valid_in);

  // Sample enables follow the tap enable with no delay
  always_comb begin
    group_sample_enable_out = CFG_MASK;
    if (!tap_enable_in) begin
      group_sample_enable_out = MASK_NONE;
    end
  end

  // Group 0 next values
  always_comb begin
    g0_nxt = downstream_msg_data_in[GROUP_W-1:0];
    q0_nxt = stream_qual(downstream_ready_in, downstream_valid_in);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      g0_r <= GROUP_ZERO;
      q0_r <= QUAL_ZERO;
    end else begin
      g0_r <= g0_nxt;
      q0_r <= q0_nxt;
    end
  end

  // Group 1 next values
  always_comb begin
    g1_nxt = upstream_msg_data_in[GROUP_W-1:0];
    q1_nxt = stream_qual(upstream_ready_in, upstream_valid_in);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      g1_r <= GROUP_ZERO;
      q1_r <= QUAL_ZERO;
    end else begin
      g1_r <= g1_nxt;
      q1_r <= q1_nxt;
    end
  end

  // Group 3 next values
  always_comb begin
    q3_nxt = {walk_rsp_valid_in, rsp_hs, walk_req_valid_in, req_hs};
    g3_nxt = {
      {G3_PAD_W{1'b0}},
      walk_rsp_id_unique_in,
      walk_rsp_poison_in,
      walk_rsp_last_in,
      walk_rsp_id_in,
      walk_rsp_ready_in,
      walk_rsp_valid_in,
      walk_req_id_in,
      walk_req_id_unique_in,
      walk_req_mpam_in,
      walk_req_domain_in,
      walk_req_user_in,
      walk_req_qos_in,
      walk_req_cache_in,
      walk_req_burst_in,
      walk_req_size_in,
      walk_req_len_in,
      walk_req_addr_in,
      walk_req_ready_in,
      walk_req_valid_in
    };
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      g3_r <= GROUP_ZERO;
      q3_r <= QUAL_ZERO;
    end else begin
      g3_r <= g3_nxt;
      q3_r <= q3_nxt;
    end
  end

  // Group 2 is pass-through so the upper message bits lead the low chunk
  always_comb begin
    q2 = {upstream_valid_in, up_hs, downstream_valid_in, dn_hs};
    g2 = {
      {G2_PAD_W{1'b0}},
      stream_side(downstream_master_id_in, downstream_msg_data_in[MSG_W-1:GROUP_W],
                  downstream_byte_keeps_in, downstream_last_in, downstream_wakeup_in,
                  downstream_ready_in, downstream_valid_in),
      stream_side(upstream_dest_id_in, upstream_msg_data_in[MSG_W-1:GROUP_W],
                  upstream_byte_keeps_in, upstream_last_in, upstream_wakeup_in,
                  upstream_ready_in, upstream_valid_in)
    };
  end

  // Groups 0, 1 and 3 leave from flip-flops; group 2 stays combinational
  assign observation_group_bus_out[GRP_DN]   = g0_r;
  assign group_qualifier_out[GRP_DN]         = q0_r;
  assign observation_group_bus_out[GRP_UP]   = g1_r;
  assign group_qualifier_out[GRP_UP]         = q1_r;
  assign observation_group_bus_out[GRP_EXT]  = g2;
  assign group_qualifier_out[GRP_EXT]        = q2;
  assign observation_group_bus_out[GRP_WALK] = g3_r;
  assign group_qualifier_out[GRP_WALK]       = q3_r;

  // Write channel and read data groups are not tapped here
  for (genvar gi = GRP_FIRST_IDLE; gi < GROUP_COUNT; gi++) begin : g_idle
    assign observation_group_bus_out[gi] = GROUP_ZERO;
    assign group_qualifier_out[gi]       = QUAL_ZERO;
  end

  // Snapshot of downstream low chunks for software that cannot run
  // an analyzer; beats are dropped while the buffer is full
  assign snap_fill.valid = dn_hs & tap_enable_in;
  assign snap_fill.data  = downstream_msg_data_in[GROUP_W-1:0];
  assign snap_room_out   = snap_fill.ready;

  snap_word_fifo #(
    .WIDTH (GROUP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_snap_fifo (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .fill_in   (snap_fill),
    .drain_out (snap_drain)
  );

  assign snap_drain.ready = snap_ready_in;
  assign snap_valid_out   = snap_drain.valid;
  assign snap_data_out    = snap_drain.data;

endmodule : translation_unit_trace_tap
`default_nettype wire

// file: verif/translation_unit_trace_tap_sva.sv
`default_nettype none
module translation_unit_trace_tap_sva
  import trace_tap_pkg::*;
#(
  parameter int WALK_DATA_WIDTH = 128
) (
  input wire logic                                 clk_in,
  input wire logic                                 rst_n_in,
  input wire logic                                 tap_enable_in,
  input wire logic [MSG_W-1:0]                     downstream_msg_data_in,
  input wire logic                                 downstream_ready_in,
  input wire logic                                 downstream_valid_in,
  input wire logic                                 upstream_ready_in,
  input wire logic                                 upstream_valid_in,
  input wire logic                                 walk_rsp_ready_in,
  input wire logic                                 walk_rsp_valid_in,
  input wire logic                                 walk_req_ready_in,
  input wire logic                                 walk_req_valid_in,
  input wire logic [ADDR_W-1:0]                    walk_req_addr_in,
  input wire logic [GROUP_COUNT-1:0][GROUP_W-1:0]  observation_group_bus_out,
  input wire logic [GROUP_COUNT-1:0][QUAL_W-1:0]   group_qualifier_out,
  input wire logic [GROUP_COUNT-1:0]               group_sample_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] MASK = (WALK_DATA_WIDTH == 512) ? 12'hFFF :
                                 (WALK_DATA_WIDTH == 256) ? 12'hCFF : 12'h47F;
  wire logic [GROUP_W-1:0] g0 = observation_group_bus_out[0];
  wire logic [GROUP_W-1:0] g2 = observation_group_bus_out[2];
  wire logic [GROUP_W-1:0] g3 = observation_group_bus_out[3];
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  en_mask_a:
    assert property (tap_enable_in |-> group_sample_enable_out == MASK) else $error("enable set");
  en_off_a:
    assert property (!tap_enable_in |-> group_sample_enable_out == '0) else $error("enable on");
  dn_delay_a:
    assert property ($past(rst_n_in) |-> g0 == $past(downstream_msg_data_in[127:0]))
    else $error("group 0 data");
  dn_qual_a:
    assert property ($past(rst_n_in) |-> group_qualifier_out[0] == $past({1'b0,
      downstream_ready_in & downstream_valid_in, downstream_ready_in, downstream_valid_in}))
    else $error("group 0 qualifier");
  ext_now_a:
    assert property (g2[117:86] == downstream_msg_data_in[159:128] && g2[127:124] == 4'h0
      && g2[62] == downstream_valid_in) else $error("group 2 layout");
  ext_qual_a:
    assert property (group_qualifier_out[2] == {upstream_valid_in, upstream_ready_in &
      upstream_valid_in, downstream_valid_in, downstream_ready_in & downstream_valid_in})
    else $error("group 2 qualifier");
  walk_qual_a:
    assert property ($past(rst_n_in) |-> group_qualifier_out[3] == $past({walk_rsp_valid_in,
      walk_rsp_ready_in & walk_rsp_valid_in, walk_req_valid_in,
      walk_req_ready_in & walk_req_valid_in})) else $error("group 3 qualifier");
  walk_addr_a:
    assert property ($past(rst_n_in) |-> g3[53:2] == $past(walk_req_addr_in) && !g3[127])
    else $error("group 3 address");
  idle_zero_a:
    assert property (observation_group_bus_out[11:4] == '0) else $error("idle group set");
  idle_qual_a:
    assert property (group_qualifier_out[11:4] == '0) else $error("idle qualifier set");

  cover property (downstream_ready_in && downstream_valid_in && tap_enable_in);
  cover property (!tap_enable_in ##1 tap_enable_in);
  cover property (walk_req_valid_in && walk_rsp_valid_in);
endmodule : translation_unit_trace_tap_sva

bind translation_unit_trace_tap translation_unit_trace_tap_sva
  #(.WALK_DATA_WIDTH(WALK_DATA_WIDTH)) u_translation_unit_trace_tap_sva (.*);
`default_nettype wire

// file: verif/snap_drain_model.sv
`default_nettype none
module snap_drain_model
  import trace_tap_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               stall_in,
  input  wire logic               snap_valid_in,
  input  wire logic [GROUP_W-1:0] snap_data_in,
  output logic                    snap_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [GROUP_W-1:0] words [$];
  initial snap_ready_out = 1'b0;
  // Ready moves only after an edge, so a stall lands one beat late
  always @(posedge clk_in) begin
    if (snap_valid_in && snap_ready_out) begin
      words.push_back(snap_data_in);
    end
    snap_ready_out <= !stall_in;
  end
endmodule : snap_drain_model
`default_nettype wire

// file: verif/tb_translation_unit_trace_tap.sv
`default_nettype none
module tb_translation_unit_trace_tap
  import trace_tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic tap_enable_in = 1'b0;
  logic stall = 1'b1;
  logic [MSG_W-1:0] downstream_msg_data_in, upstream_msg_data_in;
  logic [ID_W-1:0] downstream_master_id_in, upstream_dest_id_in;
  logic [KEEP_W-1:0] downstream_byte_keeps_in, upstream_byte_keeps_in;
  logic downstream_last_in, downstream_wakeup_in, downstream_ready_in, downstream_valid_in;
  logic upstream_last_in, upstream_wakeup_in, upstream_ready_in, upstream_valid_in;
  logic walk_rsp_id_unique_in, walk_rsp_last_in, walk_rsp_ready_in, walk_rsp_valid_in;
  logic walk_req_id_unique_in, walk_req_ready_in, walk_req_valid_in;
  logic [POISON_W-1:0] walk_rsp_poison_in;
  logic [RID_W-1:0] walk_rsp_id_in, walk_req_id_in;
  logic [MPAM_W-1:0] walk_req_mpam_in;
  logic [DOMAIN_W-1:0] walk_req_domain_in;
  logic [USER_W-1:0] walk_req_user_in;
  logic [QOS_W-1:0] walk_req_qos_in;
  logic [CACHE_W-1:0] walk_req_cache_in;
  logic [BURST_W-1:0] walk_req_burst_in;
  logic [SIZE_W-1:0] walk_req_size_in;
  logic [LEN_W-1:0] walk_req_len_in;
  logic [ADDR_W-1:0] walk_req_addr_in;
  logic [GROUP_COUNT-1:0][GROUP_W-1:0] observation_group_bus_out;
  logic [GROUP_COUNT-1:0][QUAL_W-1:0] group_qualifier_out;
  logic [GROUP_COUNT-1:0] group_sample_enable_out;
  logic [1:0][GROUP_COUNT-1:0] en_w;
  logic snap_room_out, snap_valid_out, snap_ready_in;
  logic [GROUP_W-1:0] snap_data_out;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  translation_unit_trace_tap u_translation_unit_trace_tap (.*);
  // Wider walk ports only differ in their enable sets
  for (genvar i = 0; i < 2; i++) begin : g_width
    translation_unit_trace_tap #(.WALK_DATA_WIDTH(256 << i)) u_translation_unit_trace_tap (
      .observation_group_bus_out(), .group_qualifier_out(), .group_sample_enable_out(en_w[i]),
      .snap_room_out(), .snap_valid_out(), .snap_data_out(), .*);
  end
  snap_drain_model u_snap_drain_model (.clk_in(clk_in), .stall_in(stall),
    .snap_valid_in(snap_valid_out), .snap_data_in(snap_data_out), .snap_ready_out(snap_ready_in));

  always #5 clk_in = ~clk_in;

  task automatic stop_test();
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [GROUP_W-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic set_walk(input logic [126:0] w);
    {walk_rsp_id_unique_in, walk_rsp_poison_in, walk_rsp_last_in, walk_rsp_id_in,
      walk_rsp_ready_in, walk_rsp_valid_in, walk_req_id_in, walk_req_id_unique_in,
      walk_req_mpam_in, walk_req_domain_in, walk_req_user_in, walk_req_qos_in, walk_req_cache_in,
      walk_req_burst_in, walk_req_size_in, walk_req_len_in, walk_req_addr_in, walk_req_ready_in,
      walk_req_valid_in} = w;
  endtask : set_walk

  task automatic do_reset();
    @(negedge clk_in) rst_n_in = 1'b0;
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
  endtask : do_reset

  task automatic t_enables();
    for (int t = 0; t < 2; t++) begin
      @(negedge clk_in) tap_enable_in = t[0];
      #1;
      chk("enables narrow", group_sample_enable_out, t ? 12'h47F : 12'h000);
      chk("enables mid", en_w[0], t ? 12'hCFF : 12'h000);
      chk("enables wide", en_w[1], t ? 12'hFFF : 12'h000);
    end
  endtask : t_enables

  task automatic t_stream(input logic [MSG_W-1:0] d, u);
    @(negedge clk_in);
    downstream_msg_data_in = d;
    upstream_msg_data_in = u;
    {downstream_master_id_in, downstream_byte_keeps_in} = d[25:0];
    {upstream_dest_id_in, upstream_byte_keeps_in} = u[25:0];
    {downstream_last_in, downstream_wakeup_in, downstream_ready_in, downstream_valid_in} = 4'hF;
    {upstream_last_in, upstream_wakeup_in, upstream_ready_in, upstream_valid_in} = 4'h9;
    #1;
    chk("group 2", observation_group_bus_out[2], {4'h0, d[25:20], d[159:128], d[19:0], 4'hF,
      u[25:20], u[159:128], u[19:0], 4'h9});
    chk("qualifier 2", group_qualifier_out[2], 4'hB);
    // Lower chunk trails the upper one by a cycle; fresh data proves the stage
    @(negedge clk_in);
    downstream_msg_data_in = ~d;
    upstream_msg_data_in = ~u;
    #1;
    chk("group 0", observation_group_bus_out[0], d[127:0]);
    chk("group 1", observation_group_bus_out[1], u[127:0]);
    chk("qualifiers 1 0", group_qualifier_out[1:0], 8'h17);
  endtask : t_stream

  task automatic t_walk(input logic [126:0] w);
    @(negedge clk_in) set_walk(w);
    // Inputs move on so only a true stage still shows the old word
    @(negedge clk_in) set_walk(~w);
    #1;
    chk("group 3", observation_group_bus_out[3], {1'b0, w});
    chk("qualifier 3", group_qualifier_out[3],
      {w[104], w[105] & w[104], w[0], w[1] & w[0]});
  endtask : t_walk

  task automatic t_fifo();
    int took;
    took = 0;
    @(negedge clk_in) downstream_valid_in = 1'b0;
    do_reset();
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_in);
      downstream_valid_in = 1'b1;
      downstream_msg_data_in = MSG_W'(i + 1);
      took += int'(snap_room_out);
    end
    @(negedge clk_in) downstream_valid_in = 1'b0;
    for (int k = 0; k < 80 && u_snap_drain_model.words.size() < took; k++) begin
      @(negedge clk_in) stall = k[0];
    end
    chk("accepted", GROUP_W'(took), GROUP_W'(SNAP_DEPTH + 1));
    chk("drained", GROUP_W'(u_snap_drain_model.words.size()), GROUP_W'(took));
    for (int k = 0; k < u_snap_drain_model.words.size(); k++) begin
      chk("snapshot word", u_snap_drain_model.words[k], GROUP_W'(k + 1));
    end
    @(negedge clk_in);
    chk("snapshot empty", GROUP_W'(snap_valid_out), GROUP_W'(0));
  endtask : t_fifo

  initial begin
    downstream_msg_data_in = '0;
    upstream_msg_data_in = '0;
    {downstream_master_id_in, downstream_byte_keeps_in, upstream_dest_id_in} = '0;
    upstream_byte_keeps_in = '0;
    {downstream_last_in, downstream_wakeup_in, downstream_ready_in, downstream_valid_in} = '0;
    {upstream_last_in, upstream_wakeup_in, upstream_ready_in, upstream_valid_in} = '0;
    set_walk('0);
    do_reset();
    t_enables();
    t_stream(160'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210_A5C3_5A3C,
      160'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F_C3A5_963C);
    t_stream(~160'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210_A5C3_5A3C,
      ~160'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F_C3A5_963C);
    t_walk(127'h5A3C_96F0_1E2D_4B87_A5C3_0F69_D2E1_7B4C);
    t_walk(~127'h5A3C_96F0_1E2D_4B87_A5C3_0F69_D2E1_7B4C);
    t_fifo();
    stop_test();
  end
endmodule : tb_translation_unit_trace_tap
`default_nettype wire
